// *** shared/sfm_pkg.sv ***
package sfm_pkg;
  // Widths of the vector state
  localparam int unsigned CW_W = 32;
  localparam int unsigned VEC_W = 128;
  localparam int unsigned HALF_W = 64;
  localparam int unsigned LANE_W = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned NUM_VREG = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned GPR_W = 32;

  // Exception flag positions; each mask sits MASK_LSB above its flag
  localparam int unsigned NUM_EXC = 6;
  localparam int unsigned FLAG_INVALID = 0;
  localparam int unsigned FLAG_DENORMAL = 1;
  localparam int unsigned FLAG_DIV_ZERO = 2;
  localparam int unsigned FLAG_OVERFLOW = 3;
  localparam int unsigned FLAG_UNDERFLOW = 4;
  localparam int unsigned FLAG_PRECISION = 5;
  localparam int unsigned FLAG_LSB = 0;
  localparam int unsigned MASK_LSB = 7;

  // Mode fields of the control/status word
  localparam int unsigned ZERO_DEN_BIT = 6;
  localparam int unsigned RND_LSB = 13;
  localparam int unsigned RND_W = 2;
  localparam int unsigned FLUSH_BIT = 15;
  localparam int unsigned RSVD_LSB = 16;
  localparam int unsigned RSVD_MSB = 31;

  // Reset: all six masks set, modes off, flags clear
  localparam logic [CW_W-1:0] CW_RESET = 32'h0000_1F80;

  // Single-precision field layout
  localparam int unsigned SIGN_BIT = 31;
  localparam int unsigned EXP_MSB = 30;
  localparam int unsigned EXP_LSB = 23;
  localparam int unsigned MANT_MSB = 22;

  // Address bits that must be zero for a 16-byte aligned access
  localparam int unsigned ALIGN_BITS = 4;

  // Rounding select encodings, in field order 00, 01, 10, 11
  typedef enum logic [1:0] {
    SFM_RND_NEAREST_EVEN,
    SFM_RND_DOWN,
    SFM_RND_UP,
    SFM_RND_TOWARD_ZERO
  } sfm_round_e;

  // Move and extract operations
  typedef enum logic [2:0] {
    SFM_MV_ALIGNED,
    SFM_MV_UNALIGNED,
    SFM_MV_SCALAR,
    SFM_MV_LOW_HALF,
    SFM_MV_HIGH_HALF,
    SFM_MV_LOW_TO_HIGH,
    SFM_MV_HIGH_TO_LOW,
    SFM_MV_SIGN_MASK
  } sfm_move_e;
endpackage : sfm_pkg

// *** design/sfm_operand_cond.sv ***
// Conditions one 128-bit source operand: finds denormal lanes and,
// when zeroing is on, turns each of them into a signed zero.
module sfm_operand_cond (
  input wire logic [sfm_pkg::VEC_W-1:0] raw,
  input wire logic zero_den_en,
  output logic [sfm_pkg::VEC_W-1:0] cooked,
  output logic [sfm_pkg::LANES-1:0] den_lanes
);
  localparam int unsigned LW = sfm_pkg::LANE_W;

  // One single-precision value per doubleword lane
  for (genvar i = 0; i < sfm_pkg::LANES; i++) begin : g_lane
    logic [LW-1:0] v;
    logic exp_zero;
    logic mant_nz;
    assign v = raw[i*LW +: LW];
    assign exp_zero = v[sfm_pkg::EXP_MSB:sfm_pkg::EXP_LSB] == 8'h00;
    assign mant_nz = v[sfm_pkg::MANT_MSB:0] != 23'h000000;
    assign den_lanes[i] = exp_zero && mant_nz;
    // Zero keeps the operand's own sign
    assign cooked[i*LW +: LW] = (zero_den_en && den_lanes[i]) ?
      {v[sfm_pkg::SIGN_BIT], {(LW-1){1'b0}}} : v;
  end
endmodule : sfm_operand_cond

// *** design/sfm_result_cond.sv ***
// Applies the masked flush-to-zero response to each result lane on its own.
module sfm_result_cond (
  input wire logic [sfm_pkg::VEC_W-1:0] res_in,
  input wire logic [sfm_pkg::LANES-1:0] uf_lanes,
  input wire logic flush_active,
  output logic [sfm_pkg::VEC_W-1:0] res_out,
  output logic flushed
);
  localparam int unsigned LW = sfm_pkg::LANE_W;
  logic [sfm_pkg::LANES-1:0] lane_flush;

  // Lanes are independent; one lane underflowing leaves the others as computed
  for (genvar i = 0; i < sfm_pkg::LANES; i++) begin : g_lane
    logic [LW-1:0] v;
    assign v = res_in[i*LW +: LW];
    assign lane_flush[i] = flush_active && uf_lanes[i];
    // Zero with the sign of the true result
    assign res_out[i*LW +: LW] = lane_flush[i] ?
      {v[sfm_pkg::SIGN_BIT], {(LW-1){1'b0}}} : v;
  end

  assign flushed = |lane_flush;
endmodule : sfm_result_cond

// *** design/sfm_control_and_move.sv ***
module sfm_control_and_move #(
  parameter bit ZERO_DEN_SUPPORTED = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cw_load_valid,
  input wire logic [sfm_pkg::CW_W-1:0] cw_load_data,
  output logic [sfm_pkg::CW_W-1:0] cw_word,
  output sfm_pkg::sfm_round_e rounding_select,
  input wire logic [sfm_pkg::IDX_W-1:0] rd_idx_a,
  input wire logic [sfm_pkg::IDX_W-1:0] rd_idx_b,
  output logic [sfm_pkg::VEC_W-1:0] operand_a,
  output logic [sfm_pkg::VEC_W-1:0] operand_b,
  output logic [sfm_pkg::LANES-1:0] operand_a_denormal,
  output logic [sfm_pkg::LANES-1:0] operand_b_denormal,
  input wire logic wb_valid,
  input wire logic [sfm_pkg::IDX_W-1:0] wb_dst,
  input wire logic [sfm_pkg::IDX_W-1:0] wb_src1,
  input wire logic wb_scalar,
  input wire logic [sfm_pkg::VEC_W-1:0] wb_result,
  input wire logic [sfm_pkg::LANES-1:0] wb_uf_lanes,
  input wire logic [sfm_pkg::NUM_EXC-1:0] wb_flags,
  input wire logic mv_valid,
  input wire sfm_pkg::sfm_move_e mv_op,
  input wire logic mv_mem,
  input wire logic mv_store,
  input wire logic [sfm_pkg::IDX_W-1:0] mv_dst,
  input wire logic [sfm_pkg::IDX_W-1:0] mv_src,
  input wire logic [31:0] mv_addr,
  input wire logic [sfm_pkg::VEC_W-1:0] mem_rdata,
  output logic [sfm_pkg::VEC_W-1:0] mem_wdata,
  output logic mem_store,
  output logic [sfm_pkg::GPR_W-1:0] gpr_data,
  output logic gpr_valid,
  output logic gp_fault,
  output logic simd_fp_exception
);
  localparam int unsigned LW = sfm_pkg::LANE_W;
  localparam int unsigned HW = sfm_pkg::HALF_W;
  localparam int unsigned VW = sfm_pkg::VEC_W;
  localparam int unsigned NE = sfm_pkg::NUM_EXC;
  localparam int unsigned LN = sfm_pkg::LANES;

  typedef struct packed {
    logic [sfm_pkg::CW_W-1:0] cw;
    logic [sfm_pkg::NUM_VREG-1:0][VW-1:0] vr;
    logic [VW-1:0] opa;
    logic [VW-1:0] opb;
    logic [LN-1:0] opa_den;
    logic [LN-1:0] opb_den;
    logic [VW-1:0] mem_wdata;
    logic mem_store;
    logic [sfm_pkg::GPR_W-1:0] gpr_data;
    logic gpr_valid;
    logic gp_fault;
    logic exc;
  } sfm_state_s;

  // Control word comes up masked with both modes off; vectors start at zero
  localparam sfm_state_s ST_RESET = '{cw: sfm_pkg::CW_RESET, default: '0};

  sfm_state_s r;
  sfm_state_s next_r;

  // Mode bits decoded from the live control word
  logic [NE-1:0] cur_flags;
  logic [NE-1:0] cur_masks;
  logic zero_den_on;
  logic uf_masked;
  logic flush_active;
  assign cur_flags = r.cw[sfm_pkg::FLAG_LSB +: NE];
  assign cur_masks = r.cw[sfm_pkg::MASK_LSB +: NE];
  assign zero_den_on = r.cw[sfm_pkg::ZERO_DEN_BIT];
  assign uf_masked = cur_masks[sfm_pkg::FLAG_UNDERFLOW];
  // Flush is only honoured while underflow is masked
  assign flush_active = r.cw[sfm_pkg::FLUSH_BIT] && uf_masked;

  // Load checks: reserved bits, and bit 6 on parts without zeroing
  logic cw_rsvd_bad;
  logic cw_zero_den_bad;
  logic cw_load_ok;
  assign cw_rsvd_bad = cw_load_data[sfm_pkg::RSVD_MSB:sfm_pkg::RSVD_LSB] != 16'h0000;
  assign cw_zero_den_bad = !ZERO_DEN_SUPPORTED && cw_load_data[sfm_pkg::ZERO_DEN_BIT];
  assign cw_load_ok = cw_load_valid && !cw_rsvd_bad && !cw_zero_den_bad;

  // Source operands pass through the denormal conditioner on the read port
  logic [VW-1:0] opa_cooked;
  logic [VW-1:0] opb_cooked;
  logic [LN-1:0] opa_den_raw;
  logic [LN-1:0] opb_den_raw;

  sfm_operand_cond u_cond_a (
    .raw(r.vr[rd_idx_a]),
    .zero_den_en(zero_den_on),
    .cooked(opa_cooked),
    .den_lanes(opa_den_raw)
  );

  sfm_operand_cond u_cond_b (
    .raw(r.vr[rd_idx_b]),
    .zero_den_en(zero_den_on),
    .cooked(opb_cooked),
    .den_lanes(opb_den_raw)
  );

  // A scalar result only carries its low lane, so only lane 0 may underflow
  logic [LN-1:0] uf_eff;
  logic [VW-1:0] res_fixed;
  logic res_flushed;
  assign uf_eff = wb_scalar ? {3'b000, wb_uf_lanes[0]} : wb_uf_lanes;

  sfm_result_cond u_res (
    .res_in(wb_result),
    .uf_lanes(uf_eff),
    .flush_active(flush_active),
    .res_out(res_fixed),
    .flushed(res_flushed)
  );

  // Conditions reported by this writeback after the mode rules
  logic [NE-1:0] wb_det;
  logic wb_unmasked;
  logic [VW-1:0] wb_merged;
  logic [VW-LW-1:0] wb_src1_upper;
  assign wb_src1_upper = r.vr[wb_src1][VW-1:LW];

  always_comb begin
    wb_det = wb_flags;
    if (|uf_eff) begin
      wb_det[sfm_pkg::FLAG_UNDERFLOW] = 1'b1;
    end
    // Flushed underflow is inexact as well
    if (res_flushed) begin
      wb_det[sfm_pkg::FLAG_PRECISION] = 1'b1;
      wb_det[sfm_pkg::FLAG_UNDERFLOW] = 1'b1;
    end
    // Zeroed denormals are never reported
    if (zero_den_on) begin
      wb_det[sfm_pkg::FLAG_DENORMAL] = 1'b0;
    end
  end

  // Only an executing instruction can fire; a load never does
  assign wb_unmasked = wb_valid && |(wb_det & ~cur_masks);

  // Scalar keeps the upper three lanes of the first source
  assign wb_merged = wb_scalar ? {wb_src1_upper, res_fixed[LW-1:0]} : res_fixed;

  // Sign of each lane of the move source
  logic [LN-1:0] src_signs;
  for (genvar i = 0; i < LN; i++) begin : g_sign
    assign src_signs[i] = r.vr[mv_src][i*LW + sfm_pkg::SIGN_BIT];
  end

  logic mv_misaligned;
  assign mv_misaligned = mv_addr[sfm_pkg::ALIGN_BITS-1:0] != 4'h0;

  // Next state: control load, writeback, then move; later steps win on overlap
  always_comb begin
    logic [VW-1:0] src_v;
    logic [VW-1:0] dst_v;
    logic dst_wr;
    src_v = r.vr[mv_src];
    dst_v = r.vr[mv_dst];
    dst_wr = 1'b0;
    next_r = r;
    next_r.mem_store = 1'b0;
    next_r.gpr_valid = 1'b0;
    next_r.gp_fault = 1'b0;
    next_r.exc = 1'b0;

    // Read port registers conditioned operands; denormal marks hidden under zeroing
    next_r.opa = opa_cooked;
    next_r.opb = opb_cooked;
    next_r.opa_den = zero_den_on ? 4'h0 : opa_den_raw;
    next_r.opb_den = zero_den_on ? 4'h0 : opb_den_raw;

    // A faulting load leaves the whole word untouched
    if (cw_load_valid) begin
      if (cw_load_ok) begin
        next_r.cw = cw_load_data;
      end else begin
        next_r.gp_fault = 1'b1;
      end
    end

    // New conditions are ORed after the load, so a set beats a clear
    if (wb_valid) begin
      next_r.cw[sfm_pkg::FLAG_LSB +: NE] = next_r.cw[sfm_pkg::FLAG_LSB +: NE] | wb_det;
      if (wb_unmasked) begin
        next_r.exc = 1'b1;
      end else begin
        next_r.vr[wb_dst] = wb_merged;
      end
    end

    if (mv_valid) begin
      unique case (mv_op)
        sfm_pkg::SFM_MV_ALIGNED, sfm_pkg::SFM_MV_UNALIGNED: begin
          // Only the aligned form checks the address
          if (mv_mem && mv_op == sfm_pkg::SFM_MV_ALIGNED && mv_misaligned) begin
            next_r.gp_fault = 1'b1;
          end else if (mv_mem && mv_store) begin
            next_r.mem_wdata = src_v;
            next_r.mem_store = 1'b1;
          end else begin
            dst_v = mv_mem ? mem_rdata : src_v;
            dst_wr = 1'b1;
          end
        end
        sfm_pkg::SFM_MV_SCALAR: begin
          // 4-byte access has no alignment check
          if (mv_mem && mv_store) begin
            next_r.mem_wdata = {96'h0, src_v[LW-1:0]};
            next_r.mem_store = 1'b1;
          end else begin
            dst_v[LW-1:0] = mv_mem ? mem_rdata[LW-1:0] : src_v[LW-1:0];
            dst_wr = 1'b1;
          end
        end
        sfm_pkg::SFM_MV_LOW_HALF: begin
          // Memory form only; a register form is ignored
          if (mv_mem && mv_store) begin
            next_r.mem_wdata = {64'h0, src_v[HW-1:0]};
            next_r.mem_store = 1'b1;
          end else if (mv_mem) begin
            dst_v[HW-1:0] = mem_rdata[HW-1:0];
            dst_wr = 1'b1;
          end
        end
        sfm_pkg::SFM_MV_HIGH_HALF: begin
          if (mv_mem && mv_store) begin
            next_r.mem_wdata = {64'h0, src_v[VW-1:HW]};
            next_r.mem_store = 1'b1;
          end else if (mv_mem) begin
            dst_v[VW-1:HW] = mem_rdata[HW-1:0];
            dst_wr = 1'b1;
          end
        end
        sfm_pkg::SFM_MV_LOW_TO_HIGH: begin
          dst_v[VW-1:HW] = src_v[HW-1:0];
          dst_wr = 1'b1;
        end
        sfm_pkg::SFM_MV_HIGH_TO_LOW: begin
          dst_v[HW-1:0] = src_v[VW-1:HW];
          dst_wr = 1'b1;
        end
        sfm_pkg::SFM_MV_SIGN_MASK: begin
          next_r.gpr_data = {28'h0000000, src_signs};
          next_r.gpr_valid = 1'b1;
        end
      endcase
      if (dst_wr) begin
        next_r.vr[mv_dst] = dst_v;
      end
    end
  end

  // Single state register; synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= ST_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign cw_word = r.cw;
  assign rounding_select = sfm_pkg::sfm_round_e'(r.cw[sfm_pkg::RND_LSB +: sfm_pkg::RND_W]);
  assign operand_a = r.opa;
  assign operand_b = r.opb;
  assign operand_a_denormal = r.opa_den;
  assign operand_b_denormal = r.opb_den;
  assign mem_wdata = r.mem_wdata;
  assign mem_store = r.mem_store;
  assign gpr_data = r.gpr_data;
  assign gpr_valid = r.gpr_valid;
  assign gp_fault = r.gp_fault;
  assign simd_fp_exception = r.exc;

  // Checks on the live behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_flag_sticky: assert property (
    !$past(cw_load_valid) |-> ((r.cw[5:0] & $past(r.cw[5:0])) == $past(r.cw[5:0])))
    else $error("exception flag fell without a load");

  a_reset_word: assert property (
    $rose(rstn) |-> (r.cw == sfm_pkg::CW_RESET) && !gp_fault && !simd_fp_exception)
    else $error("control word not at reset value");

  a_load_quiet: assert property (
    cw_load_valid && !wb_valid |=> !simd_fp_exception)
    else $error("control load raised an exception");

  a_round_load: assert property (
    cw_load_ok && !wb_valid |=> rounding_select == sfm_pkg::sfm_round_e'($past(cw_load_data[14:13])))
    else $error("rounding select did not follow load");

  a_flush_zero: assert property (
    wb_valid && !mv_valid && flush_active && wb_uf_lanes[0] && !wb_unmasked
    |=> (r.vr[$past(wb_dst)][30:0] == 31'h0) && r.cw[4] && r.cw[5])
    else $error("flushed underflow not zeroed or flagged");

  a_flush_ignored: assert property (
    wb_valid && !uf_masked && (|uf_eff) |=> simd_fp_exception ##1 !simd_fp_exception)
    else $error("unmasked underflow did not fire");

  a_zeroing_no_flag: assert property (
    zero_den_on && !cw_load_valid && !r.cw[1] |=> !r.cw[1] && (operand_a_denormal == 4'h0))
    else $error("denormal reported with zeroing on");

  a_zeroing_fault: assert property (
    cw_load_valid && cw_load_data[6] && !ZERO_DEN_SUPPORTED |=> gp_fault)
    else $error("bit 6 set without support did not fault");

  a_rsvd_fault: assert property (
    cw_load_valid && cw_rsvd_bad && !wb_valid |=> gp_fault && (r.cw == $past(r.cw)))
    else $error("reserved write not refused");

  a_align_fault: assert property (
    mv_valid && mv_mem && mv_misaligned && mv_op == sfm_pkg::SFM_MV_ALIGNED
    |=> gp_fault && !mem_store)
    else $error("misaligned aligned move not faulted");

  a_scalar_upper: assert property (
    wb_valid && wb_scalar && !wb_unmasked && !mv_valid
    |=> r.vr[$past(wb_dst)][VW-1:LW] == $past(wb_src1_upper))
    else $error("scalar upper lanes not passed through");

  a_sign_mask: assert property (
    mv_valid && mv_op == sfm_pkg::SFM_MV_SIGN_MASK
    |=> gpr_valid && gpr_data == {28'h0000000, $past(src_signs)} ##1 !gpr_valid || $past(mv_valid))
    else $error("sign mask extract wrong");

  c_flush: cover property (wb_valid && flush_active && (|wb_uf_lanes) ##1 r.cw[5]);
  c_align_fault: cover property (mv_valid && mv_mem && mv_misaligned ##1 gp_fault);
  c_sign_mask: cover property (mv_valid && mv_op == sfm_pkg::SFM_MV_SIGN_MASK ##1 gpr_valid);
  c_unmask_load: cover property (cw_load_ok ##1 wb_valid && wb_unmasked ##1 simd_fp_exception);
endmodule : sfm_control_and_move

// *** sim/sfm_mem_model.sv ***
// Memory seen by the move unit: answers loads at once, takes stores late
module sfm_mem_model (
  input wire logic clk_sys,
  input wire logic mv_valid,
  input wire logic mv_mem,
  input wire logic mv_store,
  input wire logic [31:0] mv_addr,
  input wire logic mem_store,
  input wire logic [sfm_pkg::VEC_W-1:0] mem_wdata,
  output logic [sfm_pkg::VEC_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] mem [16];
  logic [3:0] st_idx;
  initial begin
    foreach (mem[i]) mem[i] = '0;
  end
  // Outside a load the data is inverted, so a late sample never matches
  assign mem_rdata = (mv_valid && mv_mem && !mv_store) ? mem[mv_addr[7:4]] : ~mem[mv_addr[7:4]];
  // Store data comes a cycle after its request, so keep the address
  always @(posedge clk_sys) begin
    if (mv_valid) st_idx <= mv_addr[7:4];
    if (mem_store) mem[st_idx] <= mem_wdata;
  end
endmodule : sfm_mem_model

// *** sim/simd_fp_control_and_move_tb.sv ***
module simd_fp_control_and_move_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rstn, cw_load_valid, wb_valid, wb_scalar, mv_valid, mv_mem, mv_store;
  logic [31:0] cw_load_data, mv_addr, cw_word, gpr_data, cw, ad;
  logic [2:0] rd_idx_a, rd_idx_b, wb_dst, wb_src1, mv_dst, mv_src;
  logic [127:0] wb_result, operand_a, operand_b, mem_rdata, mem_wdata;
  logic [3:0] wb_uf_lanes, operand_a_denormal, operand_b_denormal;
  logic [5:0] wb_flags;
  logic mem_store, gpr_valid, gp_fault, simd_fp_exception, gp_fault_nz;
  sfm_pkg::sfm_round_e rounding_select;
  sfm_pkg::sfm_move_e mv_op;
  logic [127:0] vr [8];
  logic [127:0] tm [16];
  int n_errors, n_checks, cyc, i, j;

  sfm_control_and_move DUT (.clk_sys(clk_sys), .rstn(rstn), .cw_load_valid(cw_load_valid),
    .cw_load_data(cw_load_data), .cw_word(cw_word), .rounding_select(rounding_select),
    .rd_idx_a(rd_idx_a), .rd_idx_b(rd_idx_b), .operand_a(operand_a), .operand_b(operand_b),
    .operand_a_denormal(operand_a_denormal), .operand_b_denormal(operand_b_denormal),
    .wb_valid(wb_valid), .wb_dst(wb_dst), .wb_src1(wb_src1), .wb_scalar(wb_scalar),
    .wb_result(wb_result), .wb_uf_lanes(wb_uf_lanes), .wb_flags(wb_flags),
    .mv_valid(mv_valid), .mv_op(mv_op), .mv_mem(mv_mem), .mv_store(mv_store),
    .mv_dst(mv_dst), .mv_src(mv_src), .mv_addr(mv_addr), .mem_rdata(mem_rdata),
    .mem_wdata(mem_wdata), .mem_store(mem_store), .gpr_data(gpr_data),
    .gpr_valid(gpr_valid), .gp_fault(gp_fault), .simd_fp_exception(simd_fp_exception));
  sfm_mem_model u_mem (.clk_sys(clk_sys), .mv_valid(mv_valid), .mv_mem(mv_mem),
    .mv_store(mv_store), .mv_addr(mv_addr), .mem_store(mem_store),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // Twin built without zeroing support; only its load faults are compared
  sfm_control_and_move #(.ZERO_DEN_SUPPORTED(1'b0)) DUT_NO_ZEROING (.clk_sys(clk_sys),
    .rstn(rstn), .cw_load_valid(cw_load_valid), .cw_load_data(cw_load_data), .cw_word(),
    .rounding_select(), .rd_idx_a(rd_idx_a), .rd_idx_b(rd_idx_b), .operand_a(), .operand_b(),
    .operand_a_denormal(), .operand_b_denormal(), .wb_valid(wb_valid), .wb_dst(wb_dst),
    .wb_src1(wb_src1), .wb_scalar(wb_scalar), .wb_result(wb_result),
    .wb_uf_lanes(wb_uf_lanes), .wb_flags(wb_flags), .mv_valid(mv_valid), .mv_op(mv_op),
    .mv_mem(mv_mem), .mv_store(mv_store), .mv_dst(mv_dst), .mv_src(mv_src),
    .mv_addr(mv_addr), .mem_rdata(mem_rdata), .mem_wdata(), .mem_store(), .gpr_data(),
    .gpr_valid(), .gp_fault(gp_fault_nz), .simd_fp_exception());

  // Clock at 10 MHz
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the length of the run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task chk_v(input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_v
  task chk_w(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_w

  // Expected operand after conditioning with the current zeroing mode
  function automatic logic [127:0] cook(input logic [127:0] v);
    cook = v;
    for (int k = 0; k < 4; k++) begin
      if (cw[6] && v[32*k+23+:8] == 8'h00 && v[32*k+:23] != 23'h0)
        cook[32*k+:32] = {v[32*k+31], 31'h0};
    end
  endfunction : cook
  function automatic logic [3:0] dmark(input logic [127:0] v);
    for (int k = 0; k < 4; k++) dmark[k] = !cw[6] && v[32*k+23+:8] == 8'h00 && v[32*k+:23] != 23'h0;
  endfunction : dmark
  // Random lanes, half of them with a zero exponent to make denormals
  function automatic logic [127:0] rv();
    for (int k = 0; k < 4; k++) begin
      rv[32*k+:32] = $urandom;
      if ($urandom_range(1, 0) == 1) rv[32*k+23+:8] = 8'h00;
    end
  endfunction : rv

  task cw_load(input logic [31:0] d);
    logic f;
    f = d[31:16] != 16'h0;
    @(posedge clk_sys);
    cw_load_valid <= 1'b1;
    cw_load_data <= d;
    @(posedge clk_sys);
    cw_load_valid <= 1'b0;
    #1;
    if (!f) cw = d;
    chk_w(cw_word, cw);
    chk_w(32'(gp_fault), 32'(f));
    chk_w(32'(gp_fault_nz), 32'(f || d[6]));
    chk_w(32'(simd_fp_exception), 32'h0);
    chk_w(32'(rounding_select), 32'(cw[14:13]));
  endtask : cw_load

  task wb(input logic [2:0] d, input logic [2:0] s, input logic sc, input logic [127:0] r,
      input logic [3:0] u, input logic [5:0] fl);
    logic [127:0] res;
    logic [5:0] det;
    logic ue, flush, ex;
    ue = sc ? u[0] : |u;
    flush = cw[15] && cw[11];
    det = fl | (ue ? 6'h10 : 6'h00) | ((flush && ue) ? 6'h30 : 6'h00);
    if (cw[6]) det[1] = 1'b0;
    res = r;
    for (int k = 0; k < 4; k++) begin
      if (flush && u[k] && (!sc || k == 0)) res[32*k+:32] = {r[32*k+31], 31'h0};
    end
    if (sc) res[127:32] = vr[s][127:32];
    ex = |(det & ~cw[12:7]);
    @(posedge clk_sys);
    {wb_valid, wb_dst, wb_src1, wb_scalar} <= {1'b1, d, s, sc};
    {wb_result, wb_uf_lanes, wb_flags} <= {r, u, fl};
    @(posedge clk_sys);
    wb_valid <= 1'b0;
    #1;
    cw[5:0] = cw[5:0] | det;
    if (!ex) vr[d] = res;
    chk_w(cw_word, cw);
    chk_w(32'(simd_fp_exception), 32'(ex));
  endtask : wb

  task mv(input logic [2:0] op, input logic m, input logic st, input logic [2:0] d,
      input logic [2:0] s, input logic [31:0] a);
    logic [127:0] w, src;
    logic f, es;
    src = vr[s];
    w = '0;
    f = op == 3'd0 && m && a[3:0] != 4'h0;
    es = !f && m && st && op <= 3'd4;
    if (!f) begin
      case (op)
        3'd0, 3'd1: if (!m) vr[d] = src; else if (st) w = src; else vr[d] = tm[a[7:4]];
        3'd2: if (!m) vr[d][31:0] = src[31:0]; else if (st) w = {96'h0, src[31:0]};
          else vr[d][31:0] = tm[a[7:4]][31:0];
        3'd3: if (st) w = {64'h0, src[63:0]}; else vr[d][63:0] = tm[a[7:4]][63:0];
        3'd4: if (st) w = {64'h0, src[127:64]}; else vr[d][127:64] = tm[a[7:4]][63:0];
        3'd5: vr[d][127:64] = src[63:0];
        3'd6: vr[d][63:0] = src[127:64];
        default: ;
      endcase
    end
    if (es) tm[a[7:4]] = w;
    @(posedge clk_sys);
    {mv_valid, mv_mem, mv_store, mv_dst, mv_src, mv_addr} <= {1'b1, m, st, d, s, a};
    mv_op <= sfm_pkg::sfm_move_e'(op);
    @(posedge clk_sys);
    mv_valid <= 1'b0;
    #1;
    chk_w(32'(gp_fault), 32'(f));
    chk_w(32'(mem_store), 32'(es));
    if (es) chk_v(mem_wdata, w);
    chk_w(32'(gpr_valid), 32'(op == 3'd7));
    if (op == 3'd7) chk_w(gpr_data, {28'h0, src[127], src[95], src[63], src[31]});
  endtask : mv

  // Reads every register through both ports
  task rd_all();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      rd_idx_a <= 3'(k);
      rd_idx_b <= 3'(7 - k);
      @(posedge clk_sys);
      #1;
      chk_v(operand_a, cook(vr[k]));
      chk_v(operand_b, cook(vr[7-k]));
      chk_w(32'(operand_a_denormal), 32'(dmark(vr[k])));
      chk_w(32'(operand_b_denormal), 32'(dmark(vr[7-k])));
    end
  endtask : rd_all

  // Main sequence
  initial begin
    {rstn, cw_load_valid, wb_valid, wb_scalar, mv_valid, mv_mem, mv_store} = '0;
    {cw_load_data, mv_addr, rd_idx_a, rd_idx_b, wb_dst, wb_src1, mv_dst, mv_src} = '0;
    {wb_result, wb_uf_lanes, wb_flags} = '0;
    mv_op = sfm_pkg::SFM_MV_ALIGNED;
    {n_errors, n_checks, cyc} = '0;
    void'($urandom(26725));
    foreach (vr[k]) vr[k] = '0;
    foreach (tm[k]) tm[k] = '0;
    cw = 32'h0000_1F80;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    chk_w(cw_word, 32'h0000_1F80);
    for (i = 0; i < 8; i++) wb(3'(i), 3'h0, 1'b0, rv(), 4'h0, 6'h00);
    rd_all();
    for (i = 0; i < 4; i++) cw_load(32'h1F80 | (i << 13));
    cw_load(32'h0001_1F80);
    cw_load(32'h8000_1F80);
    cw_load(32'h0000_1EC0);
    rd_all();
    wb(3'h1, 3'h0, 1'b0, rv(), 4'h0, 6'h02);
    // Sticky flags, then a load that unmasks a pending flag
    cw_load(32'h0000_1F80);
    wb(3'h2, 3'h0, 1'b0, rv(), 4'h0, 6'h21);
    wb(3'h3, 3'h0, 1'b0, rv(), 4'h0, 6'h00);
    cw_load(32'h0000_1F01);
    wb(3'h4, 3'h0, 1'b0, rv(), 4'h0, 6'h00);
    wb(3'h4, 3'h0, 1'b0, rv(), 4'h0, 6'h01);
    // Flush enabled with underflow masked, then unmasked
    cw_load(32'h0000_9F80);
    wb(3'h5, 3'h1, 1'b0, rv(), 4'h5, 6'h00);
    wb(3'h6, 3'h2, 1'b1, rv(), 4'hE, 6'h00);
    wb(3'h7, 3'h3, 1'b1, rv(), 4'h1, 6'h00);
    cw_load(32'h0000_9780);
    wb(3'h0, 3'h1, 1'b0, rv(), 4'h2, 6'h00);
    rd_all();
    // Random modes, masks and writebacks
    for (j = 0; j < 48; j++) begin
      if (j % 6 == 0) cw_load({16'h0, 16'($urandom) & 16'hFFC0});
      wb(3'($urandom), 3'($urandom), 1'($urandom), rv(), 4'($urandom), 6'($urandom));
    end
    rd_all();
    cw_load(32'h0000_1F80);
    // Random moves of every kind, aligned and not
    for (j = 0; j < 80; j++) begin
      i = $urandom_range(7, 0);
      // Address is built aside so the move bus only changes on a clock edge
      ad = $urandom_range(255, 0);
      if ($urandom_range(1, 0) == 1) ad[3:0] = 4'h0;
      mv(3'(i), (i == 3 || i == 4) ? 1'b1 : (i < 3 ? 1'($urandom) : 1'b0), 1'($urandom),
        3'($urandom), 3'($urandom), ad);
    end
    rd_all();
    complete_run();
  end
endmodule : simd_fp_control_and_move_tb
